//--- hw/jtp_pkg.sv
// Shared constants and types of the test access port block.
// Assumes one system clock; all pin timing is recovered by sampling.
package jtp_pkg;

	// ----------------------------------------
	// Chain widths
	// ----------------------------------------
	localparam int JTP_IR_W = 4;
	localparam int JTP_DR_W = 32;

	// ----------------------------------------
	// Instruction codes
	// ----------------------------------------
	localparam logic [JTP_IR_W-1:0] JTP_INS_EXTEST = 4'h0;
	localparam logic [JTP_IR_W-1:0] JTP_INS_INTEST = 4'h1;
	localparam logic [JTP_IR_W-1:0] JTP_INS_SAMPLE = 4'h2;
	localparam logic [JTP_IR_W-1:0] JTP_INS_USER   = 4'h4;
	localparam logic [JTP_IR_W-1:0] JTP_INS_ABORT  = 4'h8;
	localparam logic [JTP_IR_W-1:0] JTP_INS_DPACC  = 4'ha;
	localparam logic [JTP_IR_W-1:0] JTP_INS_APACC  = 4'hb;
	localparam logic [JTP_IR_W-1:0] JTP_INS_IDCODE = 4'he;
	localparam logic [JTP_IR_W-1:0] JTP_INS_BYPASS = 4'hf;

	// ----------------------------------------
	// Capture and reset values, buffer depth
	// ----------------------------------------
	localparam logic [JTP_IR_W-1:0] JTP_IR_CAPTURE  = 4'h1;
	// Arbitrary identification value
	localparam logic [JTP_DR_W-1:0] JTP_IDCODE_DEF  = 32'h0000_0001;
	localparam int                  JTP_FIFO_DEPTH  = 8;

	// ----------------------------------------
	// Controller states, one-hot
	// ----------------------------------------
	typedef enum logic [15:0] {
		JTP_ST_TLR   = 16'h0001,
		JTP_ST_RTI   = 16'h0002,
		JTP_ST_SELDR = 16'h0004,
		JTP_ST_CAPDR = 16'h0008,
		JTP_ST_SHDR  = 16'h0010,
		JTP_ST_EX1DR = 16'h0020,
		JTP_ST_PADR  = 16'h0040,
		JTP_ST_EX2DR = 16'h0080,
		JTP_ST_UPDR  = 16'h0100,
		JTP_ST_SELIR = 16'h0200,
		JTP_ST_CAPIR = 16'h0400,
		JTP_ST_SHIR  = 16'h0800,
		JTP_ST_EX1IR = 16'h1000,
		JTP_ST_PAIR  = 16'h2000,
		JTP_ST_EX2IR = 16'h4000,
		JTP_ST_UPIR  = 16'h8000
	} jtp_state_t;

	// Which data chain sits between the serial input and output
	typedef enum logic [4:0] {
		JTP_SEL_BYP  = 5'h01,
		JTP_SEL_ID   = 5'h02,
		JTP_SEL_BS   = 5'h04,
		JTP_SEL_USR  = 5'h08,
		JTP_SEL_CORE = 5'h10
	} jtp_sel_t;

endpackage

//--- hw/jtp_sync.sv
// Two-flop synchroniser for a group of pin inputs.
// Assumes the inputs are quasi-static relative to the system clock.
`timescale 1ns/1ps
module jtp_sync #(
	parameter int             W   = 1,
	parameter logic [W-1:0]   RST = '0
) (
	// Clock, reset, enable
	input  wire logic         i_clock,
	input  wire logic         i_rst_b,
	input  wire logic         i_clk_en,
	// Data
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_sync
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} jtp_sync_reg_t;

	jtp_sync_reg_t r_reg;
	jtp_sync_reg_t r_next;

	// ----------------------------------------
	// First stage feeds only the second stage
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		if (i_clk_en) begin
			r_next.s1 = i_async;
			r_next.s2 = r_reg.s1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			r_reg <= '{s1: RST, s2: RST};
		end else begin
			r_reg <= r_next;
		end
	end

	assign o_sync = r_reg.s2;
endmodule

//--- hw/jtp_fifo.sv
// Small first-in first-out buffer with valid/ready on both sides.
// Assumes both sides run on the same clock.
`timescale 1ns/1ps
module jtp_fifo #(
	parameter int W     = 8,
	parameter int DEPTH = 8
) (
	// Clock, reset, enable
	input  wire logic         i_clock,
	input  wire logic         i_rst_b,
	input  wire logic         i_clk_en,
	// Write side
	input  wire logic         i_wr_valid,
	input  wire logic [W-1:0] i_wr_data,
	output logic              o_wr_ready,
	// Read side
	output logic              o_rd_valid,
	output logic      [W-1:0] o_rd_data,
	input  wire logic         i_rd_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][W-1:0] mem;
		logic [AW-1:0]           wr_ptr;
		logic [AW-1:0]           rd_ptr;
		logic [AW:0]             count;
	} jtp_fifo_reg_t;

	jtp_fifo_reg_t r_reg;
	jtp_fifo_reg_t r_next;
	logic          push;
	logic          pop;

	assign o_wr_ready = (r_reg.count != (AW+1)'(DEPTH));
	assign o_rd_valid = (r_reg.count != '0);
	assign o_rd_data  = r_reg.mem[r_reg.rd_ptr];

	// ----------------------------------------
	// Pointer and count update
	// ----------------------------------------
	always_comb begin
		r_next = r_reg;
		push   = i_clk_en && i_wr_valid && o_wr_ready;
		pop    = i_clk_en && i_rd_ready && o_rd_valid;
		if (push) begin
			r_next.mem[r_reg.wr_ptr] = i_wr_data;
			r_next.wr_ptr            = (r_reg.wr_ptr == AW'(DEPTH-1)) ? '0 : r_reg.wr_ptr + 1'b1;
		end
		if (pop) begin
			r_next.rd_ptr = (r_reg.rd_ptr == AW'(DEPTH-1)) ? '0 : r_reg.rd_ptr + 1'b1;
		end
		if (push && !pop) begin
			r_next.count = r_reg.count + 1'b1;
		end else if (pop && !push) begin
			r_next.count = r_reg.count - 1'b1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			r_reg <= '0;
		end else begin
			r_reg <= r_next;
		end
	end
endmodule

//--- hw/jtp_tap.sv
// Test access port controller with instruction and data shift chains.
// Assumes the test clock runs well below a quarter of the system clock.
`timescale 1ns/1ps
module jtp_tap
	import jtp_pkg::*;
#(
	parameter logic [JTP_DR_W-1:0] IDCODE_VAL = JTP_IDCODE_DEF,
	parameter int                  BS_W       = 8,
	parameter int                  DW         = 8,
	parameter int                  FIFO_DEPTH = JTP_FIFO_DEPTH
) (
	// Clock, reset, enable
	input  wire logic            i_clock,
	input  wire logic            i_rst_b,
	input  wire logic            i_clk_en,
	// Test port pins
	input  wire logic            i_tck,
	input  wire logic            i_tms,
	input  wire logic            i_tdi,
	input  wire logic            i_trst_b,
	output logic                 o_tdo,
	output logic                 o_tdo_oe,
	// Processor core test controller
	input  wire logic            i_core_tdo,
	output logic                 o_core_sel,
	// Boundary cells
	input  wire logic [BS_W-1:0] i_pin_sample,
	output logic      [BS_W-1:0] o_pin_value,
	output logic                 o_pin_test,
	output logic                 o_int_test,
	// Capture stream into the user chain
	input  wire logic            i_cap_valid,
	input  wire logic [DW-1:0]   i_cap_data,
	output logic                 o_cap_ready,
	// Update words out of the user chain
	output logic                 o_upd_valid,
	output logic      [DW-1:0]   o_upd_data,
	// Status
	output logic      [15:0]     o_tap_state
);
	// ----------------------------------------
	// State of the block
	// ----------------------------------------
	typedef struct packed {
		logic                  tck_d;
		jtp_state_t            state;
		logic [JTP_IR_W-1:0]   ir_sh;
		logic [JTP_IR_W-1:0]   ir;
		logic                  byp;
		logic [JTP_DR_W-1:0]   dr_sh;
		logic [BS_W-1:0]       bs_upd;
		logic [DW-1:0]         upd_data;
		logic                  upd_valid;
		logic                  tdo;
		logic                  tdo_oe;
	} jtp_reg_t;

	localparam jtp_reg_t RESET_VAL = '{
		state:   JTP_ST_TLR,
		ir:      JTP_INS_IDCODE,
		default: '0
	};

	jtp_reg_t            r_reg;
	jtp_reg_t            r_next;
	logic [3:0]          pins_s;
	logic                tck_s;
	logic                tms_s;
	logic                tdi_s;
	logic                trst_s_b;
	logic                tck_rise;
	logic                tck_fall;
	jtp_sel_t            sel;
	int                  len;
	logic                fifo_valid;
	logic [DW-1:0]       fifo_data;
	logic                fifo_pop;
	logic [JTP_DR_W-1:0] cap_word;
	logic [JTP_DR_W-1:0] dr_shift;
	logic                tdo_src;

	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	// Stages reset low, so test reset reads asserted until they refill
	jtp_sync #(
		.W   (4),
		.RST (4'h0)
	) u_sync (
		.i_clock  (i_clock),
		.i_rst_b  (i_rst_b),
		.i_clk_en (i_clk_en),
		.i_async  ({i_trst_b, i_tdi, i_tms, i_tck}),
		.o_sync   (pins_s)
	);

	assign tck_s    = pins_s[0];
	assign tms_s    = pins_s[1];
	assign tdi_s    = pins_s[2];
	assign trst_s_b = pins_s[3];

	// ----------------------------------------
	// Edges of the sampled test clock
	// ----------------------------------------
	// All pins share one delay so TMS and TDI line up with the edge
	assign tck_rise = tck_s && !r_reg.tck_d;
	assign tck_fall = !tck_s && r_reg.tck_d;

	// ----------------------------------------
	// Capture buffer
	// ----------------------------------------
	// Drains only on Capture-DR of the user chain, so the source sees back-pressure
	jtp_fifo #(
		.W     (DW),
		.DEPTH (FIFO_DEPTH)
	) u_fifo (
		.i_clock    (i_clock),
		.i_rst_b    (i_rst_b),
		.i_clk_en   (i_clk_en),
		.i_wr_valid (i_cap_valid),
		.i_wr_data  (i_cap_data),
		.o_wr_ready (o_cap_ready),
		.o_rd_valid (fifo_valid),
		.o_rd_data  (fifo_data),
		.i_rd_ready (fifo_pop)
	);

	// ----------------------------------------
	// Successor state
	// ----------------------------------------
	function automatic jtp_state_t next_state(input jtp_state_t s, input logic tms);
		jtp_state_t n;
		n = JTP_ST_TLR;
		case (s)
			JTP_ST_TLR:   n = tms ? JTP_ST_TLR   : JTP_ST_RTI;
			JTP_ST_RTI:   n = tms ? JTP_ST_SELDR : JTP_ST_RTI;
			JTP_ST_SELDR: n = tms ? JTP_ST_SELIR : JTP_ST_CAPDR;
			JTP_ST_CAPDR: n = tms ? JTP_ST_EX1DR : JTP_ST_SHDR;
			JTP_ST_SHDR:  n = tms ? JTP_ST_EX1DR : JTP_ST_SHDR;
			JTP_ST_EX1DR: n = tms ? JTP_ST_UPDR  : JTP_ST_PADR;
			JTP_ST_PADR:  n = tms ? JTP_ST_EX2DR : JTP_ST_PADR;
			JTP_ST_EX2DR: n = tms ? JTP_ST_UPDR  : JTP_ST_SHDR;
			JTP_ST_UPDR:  n = tms ? JTP_ST_SELDR : JTP_ST_RTI;
			JTP_ST_SELIR: n = tms ? JTP_ST_TLR   : JTP_ST_CAPIR;
			JTP_ST_CAPIR: n = tms ? JTP_ST_EX1IR : JTP_ST_SHIR;
			JTP_ST_SHIR:  n = tms ? JTP_ST_EX1IR : JTP_ST_SHIR;
			JTP_ST_EX1IR: n = tms ? JTP_ST_UPIR  : JTP_ST_PAIR;
			JTP_ST_PAIR:  n = tms ? JTP_ST_EX2IR : JTP_ST_PAIR;
			JTP_ST_EX2IR: n = tms ? JTP_ST_UPIR  : JTP_ST_SHIR;
			JTP_ST_UPIR:  n = tms ? JTP_ST_SELDR : JTP_ST_RTI;
			default:      n = JTP_ST_TLR;
		endcase
		return n;
	endfunction

	// ----------------------------------------
	// Instruction decode
	// ----------------------------------------
	always_comb begin
		case (r_reg.ir)
			JTP_INS_IDCODE: sel = JTP_SEL_ID;
			JTP_INS_SAMPLE: sel = JTP_SEL_BS;
			JTP_INS_USER:   sel = JTP_SEL_USR;
			JTP_INS_ABORT,
			JTP_INS_DPACC,
			JTP_INS_APACC:  sel = JTP_SEL_CORE;
			// Test modes hold their chains still; the bypass bit keeps the path open
			JTP_INS_EXTEST,
			JTP_INS_INTEST: sel = JTP_SEL_BYP;
			default:        sel = JTP_SEL_BYP;
		endcase
	end

	// ----------------------------------------
	// Length of the selected data chain
	// ----------------------------------------
	always_comb begin
		case (sel)
			JTP_SEL_ID:  len = JTP_DR_W;
			JTP_SEL_BS:  len = BS_W;
			JTP_SEL_USR: len = DW + 1;
			default:     len = 1;
		endcase
	end

	// ----------------------------------------
	// Parallel value each data chain captures
	// ----------------------------------------
	// An empty buffer clears the flag bit; the data bits then carry no meaning
	always_comb begin
		case (sel)
			JTP_SEL_ID:  cap_word = IDCODE_VAL;
			JTP_SEL_BS:  cap_word = JTP_DR_W'(i_pin_sample);
			JTP_SEL_USR: cap_word = JTP_DR_W'({fifo_data, fifo_valid});
			default:     cap_word = '0;
		endcase
	end

	// ----------------------------------------
	// One shift step of the data chain
	// ----------------------------------------
	// The entry bit follows the chain length, so the identification, boundary and user chains share one register
	always_comb begin
		dr_shift          = r_reg.dr_sh >> 1;
		dr_shift[len - 1] = tdi_s;
	end

	// ----------------------------------------
	// Serial output source in the data states
	// ----------------------------------------
	// Core output is taken at the fall like the local chains, so timing matches
	always_comb begin
		case (sel)
			JTP_SEL_CORE: tdo_src = i_core_tdo;
			JTP_SEL_BYP:  tdo_src = r_reg.byp;
			default:      tdo_src = r_reg.dr_sh[0];
		endcase
	end

	// ----------------------------------------
	// Next state of the whole block
	// ----------------------------------------
	// Work happens only on sampled edges or test reset, so a parked test clock changes nothing while test reset is high
	always_comb begin
		r_next           = r_reg;
		r_next.upd_valid = 1'b0;
		fifo_pop         = 1'b0;
		if (i_clk_en) begin
			r_next.tck_d = tck_s;
			if (!trst_s_b) begin
				r_next.state  = JTP_ST_TLR;
				r_next.tdo_oe = 1'b0;
			end else if (tck_rise) begin
				case (r_reg.state)
					JTP_ST_CAPIR: begin
						r_next.ir_sh = JTP_IR_CAPTURE;
					end
					JTP_ST_SHIR: begin
						r_next.ir_sh = {tdi_s, r_reg.ir_sh[JTP_IR_W-1:1]};
					end
					JTP_ST_UPIR: begin
						r_next.ir = r_reg.ir_sh;
					end
					JTP_ST_CAPDR: begin
						if (sel == JTP_SEL_BYP) begin
							r_next.byp = 1'b0;
						end else if (sel != JTP_SEL_CORE) begin
							r_next.dr_sh = cap_word;
						end
						fifo_pop = (sel == JTP_SEL_USR) && fifo_valid;
					end
					JTP_ST_SHDR: begin
						if (sel == JTP_SEL_BYP) begin
							r_next.byp = tdi_s;
						end else if (sel != JTP_SEL_CORE) begin
							r_next.dr_sh = dr_shift;
						end
					end
					JTP_ST_UPDR: begin
						if (sel == JTP_SEL_BS) begin
							r_next.bs_upd = r_reg.dr_sh[BS_W-1:0];
						end else if (sel == JTP_SEL_USR) begin
							r_next.upd_data  = r_reg.dr_sh[DW:1];
							r_next.upd_valid = 1'b1;
						end
					end
					default: begin
						r_next.byp = r_reg.byp;
					end
				endcase
				r_next.state = next_state(r_reg.state, tms_s);
			end else if (tck_fall) begin
				// Output settles half a test clock before the next sampling edge
				case (r_reg.state)
					JTP_ST_SHIR: begin
						r_next.tdo    = r_reg.ir_sh[0];
						r_next.tdo_oe = 1'b1;
					end
					JTP_ST_SHDR: begin
						r_next.tdo    = tdo_src;
						r_next.tdo_oe = 1'b1;
					end
					default: begin
						r_next.tdo_oe = 1'b0;
					end
				endcase
			end
			if (r_next.state == JTP_ST_TLR) begin
				r_next.ir = JTP_INS_IDCODE;
			end
		end
	end

	// ----------------------------------------
	// Register update
	// ----------------------------------------
	// Power-on reset wins over the clock enable, so a frozen block still resets
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			r_reg <= RESET_VAL;
		end else begin
			r_reg <= r_next;
		end
	end

	// ----------------------------------------
	// Serial port outputs
	// ----------------------------------------
	assign o_tdo       = r_reg.tdo;
	assign o_tdo_oe    = r_reg.tdo_oe;
	assign o_core_sel  = (sel == JTP_SEL_CORE);
	assign o_tap_state = r_reg.state;

	// ----------------------------------------
	// Boundary and user chain outputs
	// ----------------------------------------
	assign o_pin_value = r_reg.bs_upd;
	assign o_pin_test  = (r_reg.ir == JTP_INS_EXTEST);
	assign o_int_test  = (r_reg.ir == JTP_INS_INTEST);
	assign o_upd_valid = r_reg.upd_valid;
	assign o_upd_data  = r_reg.upd_data;
endmodule

//--- verification/jtp_tap_checker.sv
// Assertions on the ports of the test access port controller.
// Assumes binding into jtp_tap with the system clock running.
`timescale 1ns/1ps
module jtp_tap_checker
	import jtp_pkg::*;
(
	// Clock and reset
	input wire logic        i_clock,
	input wire logic        i_rst_b,
	// Pins and status
	input wire logic        i_tck,
	input wire logic        i_tms,
	input wire logic        i_trst_b,
	input wire logic        o_tdo,
	input wire logic        o_tdo_oe,
	input wire logic        o_core_sel,
	input wire logic        o_pin_test,
	input wire logic        o_upd_valid,
	input wire logic [15:0] o_tap_state
);
	// ----
	// Run of rising test clocks with select high
	// ----
	logic       tck_reg;
	logic [2:0] ones_reg;
	always_ff @(posedge i_clock) begin
		if (!i_rst_b) begin
			tck_reg  <= 1'b0;
			ones_reg <= 3'h0;
		end else begin
			tck_reg <= i_tck;
			if (i_tck && !tck_reg)
				ones_reg <= !i_tms ? 3'h0 : ones_reg + {2'h0, ones_reg != 3'h7};
		end
	end
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_b);
	// ----
	// Properties
	// ----
	property p_trst; !i_trst_b [*5] |-> o_tap_state == JTP_ST_TLR; endproperty
	property p_onehot; $onehot(o_tap_state); endproperty
	property p_oe; o_tdo_oe |-> o_tap_state inside {JTP_ST_SHDR, JTP_ST_SHIR,
		JTP_ST_EX1DR, JTP_ST_EX1IR}; endproperty
	// Synchroniser and edge detect take three cycles, so eight quiet ones suffice
	property p_hold; ($stable(i_tck) && i_trst_b) [*8] |-> $stable(o_tap_state); endproperty
	property p_five; $changed(ones_reg) && ones_reg == 3'h5 |->
		##[1:8] o_tap_state == JTP_ST_TLR; endproperty
	property p_sel; $changed(o_core_sel) |-> o_tap_state == JTP_ST_TLR ||
		$past(o_tap_state) inside {JTP_ST_UPIR, JTP_ST_TLR}; endproperty
	property p_idle; (o_tap_state == JTP_ST_TLR) [*2] |-> !o_pin_test && !o_core_sel;
	endproperty
	property p_fall; $changed(o_tdo) && o_tdo_oe |-> !$past(i_tck, 2); endproperty
	property p_upd; o_upd_valid |-> ($past(o_tap_state) == JTP_ST_UPDR ||
		$past(o_tap_state, 2) == JTP_ST_UPDR) ##1 !o_upd_valid; endproperty
	a_trst: assert property (p_trst) else $error("test reset ignored");
	a_onehot: assert property (p_onehot) else $error("bad state code");
	a_oe: assert property (p_oe) else $error("data out driven off shift");
	a_hold: assert property (p_hold) else $error("state moved, clock still");
	a_five: assert property (p_five) else $error("five highs missed");
	a_sel: assert property (p_sel) else $error("core select moved");
	a_idle: assert property (p_idle) else $error("default not loaded");
	a_fall: assert property (p_fall) else $error("data out off fall");
	a_upd: assert property (p_upd) else $error("stray update pulse");
	c_shdr: cover property (o_tap_state == JTP_ST_SHDR);
	c_upd: cover property (o_upd_valid);
	c_core: cover property (o_core_sel);
	c_five: cover property (ones_reg == 3'h5);
endmodule
bind jtp_tap jtp_tap_checker u_jtp_tap_checker (.i_clock, .i_rst_b, .i_tck, .i_tms,
	.i_trst_b, .o_tdo, .o_tdo_oe, .o_core_sel, .o_pin_test, .o_upd_valid, .o_tap_state);

//--- verification/jtp_host.sv
// Test host model driving the port pins.
// Assumes a pulled-up data-out wire; test clock idles low between frames.
`timescale 1ns/1ps
module jtp_host (
	// Alignment clock
	input  wire logic i_clock,
	// Test pins
	input  wire logic i_tdo,
	output logic      o_tck,
	output logic      o_tms,
	output logic      o_tdi,
	output logic      o_trst_b
);
	initial begin
		o_tck    = 1'b0;
		o_tms    = 1'b1;
		o_tdi    = 1'b1;
		o_trst_b = 1'b1;
	end
	task automatic set_trst(input logic v);
		o_trst_b = v;
	endtask
	// Pins move at the fall, data out is taken at the rise
	task automatic step(input logic m, input logic d, output logic q);
		o_tms = m;
		o_tdi = d;
		#62.5 o_tck = 1'b1;
		q = i_tdo;
		#62.5 o_tck = 1'b0;
	endtask
	// Scan from idle, least significant bit first, back to idle
	task automatic scan(input logic ir, input int n, input logic [31:0] din,
		output logic [31:0] dout);
		logic q;
		dout = '0;
		@(posedge i_clock) #1.3;
		step(1'b0, 1'b1, q);
		step(1'b1, 1'b1, q);
		if (ir)
			step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
		step(1'b0, 1'b1, q);
		for (int i = 0; i < n; i++) begin
			step(i == n - 1, din[i], q);
			dout[i] = q;
		end
		step(1'b1, 1'b1, q);
		step(1'b0, 1'b1, q);
	endtask
endmodule

//--- verification/jtp_tap_tb.sv
// Self-checking bench of the test access port controller.
// Assumes the host model on the pins; clock enable stays high.
`timescale 1ns/1ps
module jtp_tap_tb
	import jtp_pkg::*;
();
	logic        i_clock = 1'b0, i_rst_b = 1'b0, i_core_tdo = 1'b0, i_cap_valid = 1'b0;
	logic [7:0]  i_cap_data = 8'h00, i_pin_sample = 8'h00, upd_seen, pin_value, upd_data;
	logic        tck, tms, tdi, trst_b, tdo, tdo_oe, core_sel, pin_test, int_test;
	logic        upd_valid, cap_ready;
	logic [15:0] tap_state;
	logic [31:0] dout;
	int          miscompares = 0, num_checks = 0, upd_cnt = 0;
	wire         tdo_pin = tdo_oe ? tdo : 1'b1;
	always #4 i_clock = ~i_clock;
	jtp_tap u_jtp_tap (.i_clock, .i_rst_b, .i_clk_en(1'b1), .i_tck(tck), .i_tms(tms),
		.i_tdi(tdi), .i_trst_b(trst_b), .o_tdo(tdo), .o_tdo_oe(tdo_oe), .i_core_tdo,
		.o_core_sel(core_sel), .i_pin_sample, .o_pin_value(pin_value), .o_pin_test(pin_test),
		.o_int_test(int_test), .i_cap_valid, .i_cap_data, .o_cap_ready(cap_ready),
		.o_upd_valid(upd_valid), .o_upd_data(upd_data), .o_tap_state(tap_state));
	jtp_host u_jtp_host (.i_clock, .i_tdo(tdo_pin), .o_tck(tck), .o_tms(tms), .o_tdi(tdi),
		.o_trst_b(trst_b));
	always @(posedge i_clock) begin
		if (upd_valid === 1'b1) begin
			upd_seen <= upd_data;
			upd_cnt  <= upd_cnt + 1;
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wclk(input int n);
		repeat (n) @(posedge i_clock);
		#1;
	endtask
	task automatic to_state(input logic [3:0] path);
		logic q;
		// Realign so test clock edges never meet a system clock edge
		@(posedge i_clock) #1.3;
		for (int i = 0; i < 4; i++)
			u_jtp_host.step(path[i], 1'b1, q);
		wclk(10);
	endtask
	task automatic t_idcode;
		u_jtp_host.scan(1'b0, 32, 32'h0, dout);
		check(dout, JTP_IDCODE_DEF);
		u_jtp_host.scan(1'b1, 4, JTP_INS_IDCODE, dout);
		check(dout[3:0], JTP_IR_CAPTURE);
		wclk(10);
		check(tap_state, JTP_ST_RTI);
		$display("idcode test done");
	endtask
	task automatic t_sample;
		i_pin_sample = 8'ha5;
		u_jtp_host.scan(1'b1, 4, JTP_INS_SAMPLE, dout);
		u_jtp_host.scan(1'b0, 8, 32'h3c, dout);
		wclk(10);
		check(dout[7:0], 8'ha5);
		check(pin_value, 8'h3c);
		$display("sample test done");
	endtask
	task automatic t_codes;
		logic core;
		i_core_tdo = 1'b1;
		for (int c = 0; c < 16; c++) begin
			core = c inside {8, 10, 11};
			u_jtp_host.scan(1'b1, 4, c, dout);
			wclk(10);
			check(pin_test, c == 0);
			check(int_test, c == 1);
			check(core_sel, core);
			if (!(c inside {2, 4, 14})) begin
				u_jtp_host.scan(1'b0, 2, 32'h3, dout);
				check(dout[1:0], core ? 2'b11 : 2'b10);
			end
		end
		wclk(10);
		check(pin_value, 8'h3c);
		i_core_tdo = 1'b0;
		$display("code test done");
	endtask
	task automatic t_user;
		int n;
		n = 0;
		for (int k = 0; k < 10; k++) begin
			i_cap_valid = 1'b1;
			i_cap_data  = 8'h20 + k[7:0];
			if (cap_ready === 1'b1)
				n++;
			wclk(1);
		end
		i_cap_valid = 1'b0;
		check(n, 8);
		check(cap_ready, 1'b0);
		u_jtp_host.scan(1'b1, 4, JTP_INS_USER, dout);
		for (int k = 0; k < 9; k++) begin
			u_jtp_host.scan(1'b0, 9, {8'h40 + k[7:0], 1'b0}, dout);
			wclk(10);
			// Empty buffer: flag clear, head slot still holds the first word
			check(dout[8:0], k < 8 ? {8'h20 + k[7:0], 1'b1} : {8'h20, 1'b0});
			check(upd_seen, 8'h40 + k[7:0]);
		end
		check(upd_cnt, 9);
		check(cap_ready, 1'b1);
		$display("user chain test done");
	endtask
	task automatic t_stop;
		to_state(4'b0101);
		wclk(100);
		check(tap_state, JTP_ST_PADR);
		to_state(4'b1111);
		to_state(4'b1111);
		check(tap_state, JTP_ST_TLR);
		check(core_sel, 1'b0);
		$display("stop test done");
	endtask
	task automatic t_trst;
		u_jtp_host.scan(1'b1, 4, JTP_INS_SAMPLE, dout);
		to_state(4'b0001);
		check(tap_state, JTP_ST_SHDR);
		check(tdo_oe, 1'b1);
		u_jtp_host.set_trst(1'b0);
		wclk(10);
		check(tap_state, JTP_ST_TLR);
		check(tdo_oe, 1'b0);
		u_jtp_host.set_trst(1'b1);
		wclk(10);
		u_jtp_host.scan(1'b0, 32, 32'h0, dout);
		check(dout, JTP_IDCODE_DEF);
		to_state(4'b0001);
		i_rst_b = 1'b0;
		wclk(3);
		i_rst_b = 1'b1;
		wclk(10);
		check(tap_state, JTP_ST_TLR);
		check(tdo_oe, 1'b0);
		$display("reset test done");
	endtask
	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	initial begin
		wclk(4);
		i_rst_b = 1'b1;
		wclk(10);
		t_idcode;
		t_sample;
		t_codes;
		t_user;
		t_stop;
		t_trst;
		tally_and_finish;
	end
	initial begin
		repeat (60000) @(posedge i_clock);
		miscompares++;
		tally_and_finish;
	end
endmodule
